// >>> src/hbpd_pkg.sv
// package for the half-bridge protection and diagnostic block
// assumes a 125 MHz core clock and a slow serial link sampled by it
package hbpd_pkg;

    // core clock period and timing figures
    localparam int CLK_PERIOD_NS = 8;
    localparam int UV_FILTER_US = 10;
    localparam int UV_FILTER_CYC = (UV_FILTER_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int SD_DELAY_NS = 1000;
    localparam int SD_DELAY_CYC = (SD_DELAY_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int NUM_SW = 6;
    localparam int WORD_BITS = 16;

    // control word field positions
    localparam int CB_STATUS_RESET = 0;
    localparam int CB_SW_LO = 1;
    localparam int CB_PWM_LO = 7;
    localparam int CB_OLD = 13;
    localparam int CB_OCS = 14;
    localparam int CB_SI = 15;

    // status word field positions
    localparam int SB_PREWARN = 0;
    localparam int SB_SW_LO = 1;
    localparam int SB_OVERLOAD = 13;
    localparam int SB_STANDBY = 14;
    localparam int SB_SUPPLY_FAIL = 15;

    // control word after reset
    localparam logic [15:0] CTRL_RESET = 16'he000;

    // decoded control word
    typedef struct packed {
        logic inhibit_n;
        logic ocs_enable;
        logic open_load_enable_n;
        logic [5:0] pwm_sel;
        logic [5:0] switch_on;
        logic status_reset_cmd;
    } hbpd_ctrl_t;

    // per-switch analog sense inputs
    typedef struct packed {
        logic [5:0] over_temp;
        logic [5:0] temp_ok;
        logic [5:0] over_current;
        logic [5:0] open_load;
        logic [5:0] prewarn;
    } hbpd_sense_t;

    // serial link state
    typedef enum logic [2:0] {
        LINK_IDLE = 3'b001,
        LINK_SHIFT = 3'b010,
        LINK_DONE = 3'b100
    } hbpd_link_t;

endpackage

// >>> src/hbpd_core.sv
// protection, diagnostics and serial link of a triple half-bridge driver
// assumes analog comparators arrive as async levels; link pins async too
`timescale 1ns/10ps

module hbpd_core
    import hbpd_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // serial link pins
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // pwm pin
    input wire logic pwm_in,
    // analog sense comparators
    input wire logic undervoltage_in,
    input wire hbpd_sense_t sense_in,
    // output stage drive and detection currents
    output logic [5:0] gate_on_out,
    output logic [5:0] old_current_on_out
);

    // synchronisers: stage one is read only by stage two
    logic [4:0] sync1, sync2;
    hbpd_sense_t sense1, sense2;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sync1 <= 5'h16; // idle levels, so no false edge after reset
            sync2 <= 5'h16;
            sense1 <= '0;
            sense2 <= '0;
        end
        else
        begin
            sync1 <= {cs_n_in, sclk_in, sdi_in, pwm_in, undervoltage_in};
            sync2 <= sync1;
            sense1 <= sense_in;
            sense2 <= sense1;
        end
    end

    logic cs_s, clk_s, di_s, pwm_s, uv_s;
    assign {cs_s, clk_s, di_s, pwm_s, uv_s} = sync2;

    // edge detect on synchronised link pins
    logic cs_d, clk_d;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cs_d <= 1'b1;
            clk_d <= 1'b0;
        end
        else
        begin
            cs_d <= cs_s;
            clk_d <= clk_s;
        end
    end
    logic cs_fall, cs_rise, clk_rise, clk_fall;
    assign cs_fall = cs_d & ~cs_s;
    assign cs_rise = ~cs_d & cs_s;
    assign clk_rise = ~clk_d & clk_s;
    assign clk_fall = clk_d & ~clk_s;

    // undervoltage filter and supply fail
    localparam int UVW = $clog2(UV_FILTER_CYC + 1);
    logic [UVW-1:0] uv_cnt;
    logic uv_active, supply_fail_flag, status_reset_pulse;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            uv_cnt <= '0;
            uv_active <= 1'b0;
        end
        else if (!uv_s)
        begin
            uv_cnt <= '0;
            uv_active <= 1'b0; // release at once on recovery
        end
        else if (uv_cnt == UVW'(UV_FILTER_CYC))
            uv_active <= 1'b1; // only persisting dips count
        else
            uv_cnt <= uv_cnt + 1'b1;
    end

    // set wins over the status reset
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            supply_fail_flag <= 1'b0;
        else if (uv_active)
            supply_fail_flag <= 1'b1;
        else if (status_reset_pulse)
            supply_fail_flag <= 1'b0;
    end

    // serial shifter; sdo shows status msb-first after prewarn
    hbpd_link_t link_state;
    logic [15:0] shift_in, shift_out, status_word;
    logic [4:0] bit_cnt;
    logic [15:0] ctrl_word;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            link_state <= LINK_IDLE;
            shift_in <= '0;
            shift_out <= '0;
            bit_cnt <= '0;
        end
        else
        begin
            unique case (link_state)
                LINK_IDLE:
                    if (cs_fall)
                    begin
                        shift_out <= {status_word[SB_PREWARN],
                            status_word[WORD_BITS-1:1]};
                        bit_cnt <= '0;
                        link_state <= LINK_SHIFT;
                    end
                LINK_SHIFT:
                    if (cs_rise)
                        link_state <= LINK_IDLE; // aborted frame
                    else if (clk_rise)
                    begin
                        shift_in <= {shift_in[14:0], di_s};
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == 5'(WORD_BITS - 1))
                            link_state <= LINK_DONE;
                    end
                    else if (clk_fall)
                        shift_out <= {shift_out[14:0], 1'b0};
                LINK_DONE:
                    if (cs_rise)
                        link_state <= LINK_IDLE;
            endcase
        end
    end

    // latch control word only on a complete frame
    logic frame_done;
    assign frame_done = (link_state == LINK_DONE) && cs_rise;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ctrl_word <= CTRL_RESET;
            status_reset_pulse <= 1'b0;
        end
        else
        begin
            status_reset_pulse <= frame_done && shift_in[CB_STATUS_RESET];
            if (frame_done)
                ctrl_word <= shift_in;
        end
    end

    hbpd_ctrl_t ctrl;
    assign ctrl = hbpd_ctrl_t'(ctrl_word);

    // data out: prewarn bit first, then status word
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sdo_out <= 1'b0;
            sdo_oe_out <= 1'b0;
        end
        else
        begin
            sdo_oe_out <= !cs_s;
            if (link_state == LINK_IDLE)
                sdo_out <= status_word[SB_PREWARN];
            else
                sdo_out <= shift_out[WORD_BITS-1];
        end
    end

    // per-switch overload latch; shutdown delay counters
    localparam int SDW = $clog2(SD_DELAY_CYC + 1);
    logic [5:0] overload_off;
    logic [SDW-1:0] sd_cnt [NUM_SW];
    genvar g;
    generate
        for (g = 0; g < NUM_SW; g++)
        begin : g_sw
            always_ff @(posedge clock_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    sd_cnt[g] <= '0;
                else if (!(ctrl.ocs_enable && sense2.over_current[g]))
                    sd_cnt[g] <= '0; // limit only
                else if (sd_cnt[g] != SDW'(SD_DELAY_CYC))
                    sd_cnt[g] <= sd_cnt[g] + 1'b1;
            end
            always_ff @(posedge clock_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    overload_off[g] <= 1'b0;
                else if (sense2.over_temp[g])
                    overload_off[g] <= 1'b1;
                else if (sd_cnt[g] == SDW'(SD_DELAY_CYC))
                    overload_off[g] <= 1'b1;
                else if (status_reset_pulse && sense2.temp_ok[g])
                    overload_off[g] <= 1'b0;
            end
        end
    endgenerate

    // overload flag; events win over the status reset
    logic overload_flag;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            overload_flag <= 1'b0;
        else if (|(sense2.over_temp & ~overload_off))
            overload_flag <= 1'b1;
        else if (|overload_off && !status_reset_pulse)
            overload_flag <= 1'b1; // set again while any is off, except in the status reset cycle
        else if (status_reset_pulse)
            overload_flag <= 1'b0;
    end

    // output drive: enable, pwm gating, inhibit, supply, overload
    logic [5:0] next_gate;
    always_comb
    begin
        next_gate = ctrl.switch_on & ~(ctrl.pwm_sel & {NUM_SW{~pwm_s}});
        if (!ctrl.inhibit_n || uv_active)
            next_gate = '0;
        next_gate = next_gate & ~overload_off;
    end

    // status word assembly
    logic temp_prewarn_flag;
    logic [5:0] sw_status;
    always_comb
    begin
        temp_prewarn_flag = |sense2.prewarn;
        if (!ctrl.open_load_enable_n)
            sw_status = sense2.open_load & ~ctrl.switch_on;
        else
            sw_status = gate_on_out; // off shows low
        status_word = '0;
        status_word[SB_PREWARN] = temp_prewarn_flag;
        status_word[SB_SW_LO +: NUM_SW] = sw_status;
        status_word[SB_OVERLOAD] = overload_flag;
        status_word[SB_STANDBY] = !ctrl.inhibit_n;
        status_word[SB_SUPPLY_FAIL] = supply_fail_flag;
    end

    // registered drive and detection current enables
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            gate_on_out <= '0;
            old_current_on_out <= '0;
        end
        else
        begin
            gate_on_out <= next_gate;
            old_current_on_out <= {NUM_SW{!ctrl.open_load_enable_n}}
                & ~ctrl.switch_on; // undriven only
        end
    end

    // supply fail is set the cycle after a filtered dip
    sequence uv_seen_s;
        uv_active;
    endsequence
    supply_fail_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) uv_seen_s |=> supply_fail_flag)
        else $error("supply fail not set");
    uv_gate_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) uv_active |=> gate_on_out == 6'h00)
        else $error("outputs live during undervoltage");
    uv_filter_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        $rose(uv_active) |-> $past(uv_cnt) == UVW'(UV_FILTER_CYC))
        else $error("undervoltage taken too early");
    inhibit_off_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !ctrl.inhibit_n |=> gate_on_out == 6'h00)
        else $error("outputs live while inhibited");
    psf_hold_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        supply_fail_flag && !status_reset_pulse |=> supply_fail_flag)
        else $error("supply fail dropped without reset");
    abort_keep_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !frame_done |=> $stable(ctrl_word))
        else $error("control changed without full frame");
    ovl_clear_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        status_reset_pulse && !(|sense2.over_temp) && !(|overload_off)
        |=> !overload_flag)
        else $error("overload not cleared");
    ocs_off_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !ctrl.ocs_enable |=> sd_cnt[4] == '0)
        else $error("overcurrent timing without enable");
    thermal_off_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) sense2.over_temp[2] |=> ##1 !gate_on_out[2])
        else $error("hot output not disabled");

endmodule

// >>> bench/hbpd_mcu_model.sv
// microcontroller model: drives chip select, serial clock and data in
// assumes the core samples these pins with its own faster clock
`timescale 1ns/10ps
module hbpd_mcu_model
(
    // core clock, only paces the link
    input wire logic clock_in,
    // serial link pins
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    // idle link: deselected, clock parked low
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b1;
    end

    // frame of nbits at 64 ns; st gets prewarning, then bits 15..1
    // data moves on the fall so it is settled at the rise
    task automatic xfer(input logic [15:0] tx, input int nbits,
        output logic [15:0] st);
        st = 16'h0000;
        @(posedge clock_in);
        cs_n_out <= 1'b0;
        sdi_out <= tx[15];
        repeat (8) @(posedge clock_in);
        st[0] = sdo_in;
        for (int i = 0; i < nbits; i++)
        begin
            sclk_out <= 1'b1;
            repeat (4) @(posedge clock_in);
            // read late in the high phase: data out lags a fall by 4 clocks
            if (i > 0)
                st[16 - i] = sdo_in;
            sclk_out <= 1'b0;
            sdi_out <= (i < 15) ? tx[14 - i] : ~tx[0];
            repeat (4) @(posedge clock_in);
        end
        // a short count ends here, aborting the frame
        cs_n_out <= 1'b1;
        sdi_out <= ~sdi_out;
        repeat (8) @(posedge clock_in);
    endtask
endmodule

// >>> bench/test_hbpd_core.sv
// self-checking bench for the half-bridge protection core
// assumes the mcu model owns the link; sense and pwm come from here
`timescale 1ns/10ps
module test_hbpd_core;
    import hbpd_pkg::*;
    logic clock_in;
    logic resetn_in;
    logic cs_n, sclk, sdi, sdo, sdo_oe, pwm, uv;
    logic sdo_line;
    hbpd_sense_t sense;
    logic [5:0] gate;
    logic [5:0] cur;
    logic [5:0] e;
    logic [15:0] m;
    logic [15:0] ctrl;
    logic [15:0] st;
    int bad_count;
    int compares;

    hbpd_core u_hbpd_core (.clock_in(clock_in), .resetn_in(resetn_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo),
        .sdo_oe_out(sdo_oe), .pwm_in(pwm), .undervoltage_in(uv),
        .sense_in(sense), .gate_on_out(gate), .old_current_on_out(cur));
    hbpd_mcu_model mcu (.clock_in(clock_in), .cs_n_out(cs_n),
        .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo_line));

    // released data line shows the inverse, so a missing enable is seen
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    // core clock
    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic test_done;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // expected gates from control word, pwm level and tripped switches
    function automatic logic [5:0] exp_gate(input logic [15:0] c,
        input logic p, input logic [5:0] trip);
        exp_gate = c[CB_SW_LO +: 6] & ~(c[CB_PWM_LO +: 6] & {6{~p}})
            & ~trip & {6{c[CB_SI]}};
    endfunction

    // bounded wait for the gates; a hang ends the run
    task automatic wait_gate(input logic [5:0] exp);
        for (int n = 0; n < 24 && gate !== exp; n++)
            @(posedge clock_in);
        chk({10'h000, gate}, {10'h000, exp});
        if (gate !== exp)
            test_done();
    endtask

    task automatic frame(input logic [15:0] c);
        mcu.xfer(c, 16, st);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        resetn_in = 1'b0;
        pwm = 1'b1;
        uv = 1'b0;
        sense = '0;
        sense.temp_ok = 6'h3f;
        bad_count = 0;
        compares = 0;
        idle(5);
        resetn_in <= 1'b1;
        idle(3);
        chk({9'h000, sdo_oe, gate}, 16'h0000);
        chk({10'h000, cur}, 16'h0000);
        void'($urandom(80559));
        // random words; pwm held long enough for the low-side rate
        for (int k = 0; k < 6; k++)
        begin
            ctrl = 16'hc000 | (16'($urandom) & 16'h3ffe);
            pwm <= 1'($urandom);
            idle(7900);
            frame(ctrl);
            wait_gate(exp_gate(ctrl, pwm, 6'h00));
            e = ctrl[CB_OLD] ? 6'h00 : ~ctrl[CB_SW_LO +: 6];
            if (pwm)
                chk({10'h000, cur}, {10'h000, e});
            frame(ctrl);
            e = ctrl[CB_OLD] ? exp_gate(ctrl, pwm, 6'h00) : 6'h00;
            m = ctrl[CB_OLD] ? 16'he07e : 16'he000;
            chk(st & m, {9'h000, e, 1'b0});
        end
        pwm <= 1'b1;
        idle(7900);
        // all off with detection on: one result per switch
        sense.open_load <= 6'($urandom);
        ctrl = 16'hc000;
        frame(ctrl);
        frame(ctrl);
        chk({10'h000, cur}, 16'h003f);
        chk(st & 16'h007e, {9'h000, sense.open_load, 1'b0});
        sense.open_load <= 6'h00;
        // standby drops every stage while the link still answers
        ctrl = 16'h607e;
        frame(ctrl);
        wait_gate(6'h00);
        frame(ctrl);
        chk(st & 16'h4000, 16'h4000);
        ctrl = 16'he07e;
        frame(ctrl);
        wait_gate(6'h3f);
        // dip shorter than the filter, then a real one
        uv <= 1'b1;
        idle(UV_FILTER_CYC - 50);
        uv <= 1'b0;
        idle(8);
        chk({10'h000, gate}, 16'h003f);
        frame(ctrl);
        chk(st & 16'h8000, 16'h0000);
        uv <= 1'b1;
        idle(UV_FILTER_CYC + 20);
        chk({10'h000, gate}, 16'h0000);
        uv <= 1'b0;
        wait_gate(6'h3f);
        frame(ctrl);
        frame(ctrl);
        chk(st & 16'h8000, 16'h8000);
        frame(ctrl | 16'h0001);
        frame(ctrl);
        chk(st & 16'h8000, 16'h0000);
        // overheat on one switch: back only when cool and reset
        sense.over_temp[2] <= 1'b1;
        sense.temp_ok[2] <= 1'b0;
        wait_gate(6'h3b);
        sense.over_temp[2] <= 1'b0;
        frame(ctrl);
        chk(st & 16'h207e, 16'h2076);
        frame(ctrl | 16'h0001);
        idle(16);
        chk({10'h000, gate}, 16'h003b);
        sense.temp_ok[2] <= 1'b1;
        idle(16);
        chk({10'h000, gate}, 16'h003b);
        frame(ctrl | 16'h0001);
        wait_gate(6'h3f);
        frame(ctrl);
        chk(st & 16'h2000, 16'h0000);
        // overcurrent trips only after the delay
        sense.over_current[4] <= 1'b1;
        idle(SD_DELAY_CYC - 20);
        chk({10'h000, gate}, 16'h003f);
        idle(40);
        chk({10'h000, gate}, 16'h002f);
        sense.over_current[4] <= 1'b0;
        frame(ctrl);
        chk(st & 16'h207e, 16'h205e);
        frame(ctrl | 16'h0001);
        wait_gate(6'h3f);
        // shutdown disabled: current only limited
        ctrl = 16'ha07e;
        frame(ctrl);
        sense.over_current[4] <= 1'b1;
        idle(SD_DELAY_CYC + 40);
        frame(ctrl);
        chk(st & 16'h207e, 16'h007e);
        sense.over_current[4] <= 1'b0;
        // prewarning read alone; aborted frames change nothing
        sense.prewarn[1] <= 1'b1;
        idle(8);
        mcu.xfer(16'h0000, 0, st);
        chk(st & 16'h0001, 16'h0001);
        mcu.xfer(16'h0000, 5, st);
        idle(8);
        chk({10'h000, gate}, 16'h003f);
        sense.prewarn[1] <= 1'b0;
        idle(8);
        frame(ctrl);
        chk(st & 16'h0001, 16'h0000);
        test_done();
    end
endmodule
